// *** irq_regs_pkg.sv ***
// constants for the interrupt enable and priority register set.
// assumes a 40 MHz core clock, synchronous active-high reset and an apb master.
// Functional notes
// - base priority bit 0 picks external interrupt 0 level: 0 low, 1 high
// - enable one bit 1 masks bus controller interrupt: 0 blocks, 1 passes
// - enable one bits 7 to 2 read zero, writes to them ignored
// - enable one bit 0 reads zero, writes to it ignored
// - priority two bit 0 sets supply level priority, 0 low; bits 7-1 read-only
package irq_regs_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  // printed offsets are register indexes; byte address is index times four
  localparam logic [7:0] EXTENDED_ENABLE_ONE_IDX = 8'hE6;
  localparam logic [7:0] EXTENDED_PRIORITY_TWO_IDX = 8'hF7;
  localparam logic [7:0] BASE_PRIORITY_REGISTER_IDX = 8'h20;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;
  localparam int unsigned PAGE_LSB = 10;
  localparam logic [1:0] WORD_ALIGNED = 2'h0;
  localparam logic [21:0] PAGE_ZERO = 22'h000000;
  localparam logic [7:0] BASE_PRIORITY_RESET = 8'h00;
  localparam logic EXTENDED_ENABLE_ONE_RESET = 1'b0;
  localparam logic EXTENDED_PRIORITY_TWO_RESET = 1'b0;
  localparam int unsigned EXT_IRQ_ZERO_PRIORITY_BIT = 0;
  localparam int unsigned BUS_CONTROLLER_IRQ_ENABLE_BIT = 1;
  localparam int unsigned SUPPLY_LEVEL_IRQ_PRIORITY_BIT = 0;
  localparam logic [7:0] REG_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;
endpackage

// *** reg_access_if.sv ***
// carries decoded register accesses from the apb port to the register set.
// assumes both ends run on the same core clock.
interface reg_access_if;
  logic [7:0] idx;
  logic aligned;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] rdata;
  logic hit;
  modport port (output idx, output aligned, output wdata, output wr, input rdata, input hit);
  modport regs (input idx, input aligned, input wdata, input wr, output rdata, output hit);
endinterface

// *** apb_reg_port.sv ***
// apb slave front end: decodes the word index and answers one cycle after setup.
// assumes an apb master that holds the request until pready is seen.
module apb_reg_port
  import irq_regs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // register side
  reg_access_if.port acc
);
  import irq_regs_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_state_t;

  apb_state_t st;
  apb_state_t next_st;
  logic setup;

  assign setup = psel_i & ~penable_i;
  assign acc.idx = paddr_i[IDX_MSB:IDX_LSB];
  assign acc.aligned = (paddr_i[1:0] == WORD_ALIGNED) && (paddr_i[31:PAGE_LSB] == PAGE_ZERO);
  assign acc.wdata = pwdata_i[REG_W-1:0];
  // write lands only on the completing edge, and never on an error answer
  assign acc.wr = psel_i & penable_i & st.pready & pwrite_i & ~st.pslverr;

  always_comb begin
    next_st = st;
    // answer is registered in setup, so pready comes one cycle later
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = ~acc.hit;
      next_st.prdata = (pwrite_i || !acc.hit) ? WORD_ZERO : {UPPER_ZERO, acc.rdata};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
endmodule

// *** interrupt_enable_priority_regs.sv ***
// interrupt enable and priority registers reached over apb.
// assumes the core's arbiter reads the priority outputs and the gated request.
//
// Decided for this implementation: the APB interface to the registers.
module interrupt_enable_priority_regs
  import irq_regs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt sources and settings to the core
  input wire logic bus_function_controller_irq_i,
  output logic bus_function_controller_irq_o,
  output logic ext_irq_zero_priority_o,
  output logic bus_controller_irq_enable_o,
  output logic supply_level_irq_priority_o
);
  import irq_regs_pkg::*;

  typedef struct packed {
    logic [7:0] base_priority_register;
    logic bus_controller_irq_enable;
    logic supply_level_irq_priority;
    logic bus_irq_req;
  } regs_state_t;

  regs_state_t st;
  regs_state_t next_st;
  reg_access_if acc ();

  apb_reg_port u_port (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .acc(acc)
  );

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == EXTENDED_ENABLE_ONE_IDX) || (idx == EXTENDED_PRIORITY_TWO_IDX)
      || (idx == BASE_PRIORITY_REGISTER_IDX);
  endfunction

  function automatic logic [7:0] read_value(input logic [7:0] idx, input regs_state_t s);
    read_value = REG_ZERO;
    case (idx)
      BASE_PRIORITY_REGISTER_IDX: begin
        read_value = s.base_priority_register;
      end
      EXTENDED_ENABLE_ONE_IDX: begin
        // unused bits come from constant zero, not storage
        read_value[BUS_CONTROLLER_IRQ_ENABLE_BIT] = s.bus_controller_irq_enable;
      end
      EXTENDED_PRIORITY_TWO_IDX: begin
        read_value[SUPPLY_LEVEL_IRQ_PRIORITY_BIT] = s.supply_level_irq_priority;
      end
      default: begin
        read_value = REG_ZERO;
      end
    endcase
  endfunction

  assign acc.hit = acc.aligned & is_mapped(acc.idx);
  assign acc.rdata = read_value(acc.idx, st);

  always_comb begin
    next_st = st;
    if (acc.wr) begin
      case (acc.idx)
        BASE_PRIORITY_REGISTER_IDX: begin
          next_st.base_priority_register = acc.wdata;
        end
        EXTENDED_ENABLE_ONE_IDX: begin
          // only the enable bit is stored; the rest of the byte is dropped
          next_st.bus_controller_irq_enable = acc.wdata[BUS_CONTROLLER_IRQ_ENABLE_BIT];
        end
        EXTENDED_PRIORITY_TWO_IDX: begin
          // 0 low, 1 high; bits 7-1 have no storage
          next_st.supply_level_irq_priority = acc.wdata[SUPPLY_LEVEL_IRQ_PRIORITY_BIT];
        end
        default: begin
          next_st = st;
        end
      endcase
    end
    // request passes one flop later; gating uses the enable already in force
    next_st.bus_irq_req = bus_function_controller_irq_i & st.bus_controller_irq_enable;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st.base_priority_register <= BASE_PRIORITY_RESET;
      st.bus_controller_irq_enable <= EXTENDED_ENABLE_ONE_RESET;
      st.supply_level_irq_priority <= EXTENDED_PRIORITY_TWO_RESET;
      st.bus_irq_req <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign ext_irq_zero_priority_o = st.base_priority_register[EXT_IRQ_ZERO_PRIORITY_BIT];
  assign bus_controller_irq_enable_o = st.bus_controller_irq_enable;
  assign supply_level_irq_priority_o = st.supply_level_irq_priority;
  assign bus_function_controller_irq_o = st.bus_irq_req;

  // byte address of a mapped register, page zero and word aligned
  function automatic logic [31:0] byte_addr(input logic [7:0] idx);
    byte_addr = {PAGE_ZERO, idx, WORD_ALIGNED};
  endfunction

  // completing edges of a transfer, as seen on the pins
  logic apb_write_done;
  logic apb_read_done;
  assign apb_write_done = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign apb_read_done = psel_i & penable_i & pready_o & ~pwrite_i;

  a_ext_zero_prio: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_write_done && paddr_i == byte_addr(BASE_PRIORITY_REGISTER_IDX)
    |=> ext_irq_zero_priority_o == $past(pwdata_i[EXT_IRQ_ZERO_PRIORITY_BIT]))
    else $error("external interrupt 0 priority did not follow write");

  a_base_read_value: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_read_done && paddr_i == byte_addr(BASE_PRIORITY_REGISTER_IDX)
    |-> prdata_o[DATA_W-1:REG_W] == UPPER_ZERO
    && prdata_o[EXT_IRQ_ZERO_PRIORITY_BIT] == ext_irq_zero_priority_o)
    else $error("base priority read value wrong");

  a_bus_irq_blocked: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !bus_controller_irq_enable_o |=> !bus_function_controller_irq_o)
    else $error("bus controller request passed while masked");

  a_bus_irq_passed: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bus_controller_irq_enable_o && bus_function_controller_irq_i
    |=> bus_function_controller_irq_o)
    else $error("enabled bus controller request was lost");

  a_bus_irq_follows: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    bus_function_controller_irq_o
    == $past(bus_function_controller_irq_i && bus_controller_irq_enable_o))
    else $error("gated request does not follow source and mask");

  a_enable_write_bit: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_write_done && paddr_i == byte_addr(EXTENDED_ENABLE_ONE_IDX)
    |=> bus_controller_irq_enable_o == $past(pwdata_i[BUS_CONTROLLER_IRQ_ENABLE_BIT]))
    else $error("bus controller enable did not follow write");

  a_enable_high_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_read_done && paddr_i == byte_addr(EXTENDED_ENABLE_ONE_IDX)
    |-> prdata_o[31:2] == 30'h0)
    else $error("unused upper enable bits read non-zero");

  a_enable_low_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_read_done && paddr_i == byte_addr(EXTENDED_ENABLE_ONE_IDX)
    |-> prdata_o[0] == 1'b0 && prdata_o[1] == bus_controller_irq_enable_o)
    else $error("enable register read value wrong");

  a_supply_prio_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_write_done && paddr_i == byte_addr(EXTENDED_PRIORITY_TWO_IDX) && !pwdata_i[0]
    |=> !supply_level_irq_priority_o)
    else $error("supply level priority not low after writing 0");

  a_supply_prio_high: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_write_done && paddr_i == byte_addr(EXTENDED_PRIORITY_TWO_IDX) && pwdata_i[0]
    |=> supply_level_irq_priority_o ##1 (supply_level_irq_priority_o || apb_write_done))
    else $error("supply level priority not high after writing 1");

  a_prio_two_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    apb_read_done && paddr_i == byte_addr(EXTENDED_PRIORITY_TWO_IDX)
    |-> prdata_o == {31'h0, supply_level_irq_priority_o})
    else $error("priority two read value wrong");

  // settings may only move on a completed, accepted write
  a_regs_hold_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !apb_write_done
    |=> $stable(ext_irq_zero_priority_o) && $stable(bus_controller_irq_enable_o)
    && $stable(supply_level_irq_priority_o))
    else $error("register setting changed without a write");

  a_reset_clears: assert property (@(posedge core_clk_i)
    $fell(sys_rst_i) |-> !ext_irq_zero_priority_o && !bus_controller_irq_enable_o
    && !supply_level_irq_priority_o && !bus_function_controller_irq_o && !pready_o)
    else $error("outputs not at reset level after reset release");

  a_answer_one_cycle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("apb answer not exactly one cycle after setup");

  a_ready_after_setup: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    pready_o |-> $past(psel_i && !penable_i))
    else $error("apb answer without a setup cycle");

  a_refused_address: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    psel_i && !penable_i
    && (paddr_i[1:0] != WORD_ALIGNED || paddr_i[DATA_W-1:PAGE_LSB] != PAGE_ZERO)
    |=> pslverr_o)
    else $error("misaligned or out-of-page access not refused");

  a_mapped_accepted: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    psel_i && !penable_i
    && (paddr_i == byte_addr(BASE_PRIORITY_REGISTER_IDX)
    || paddr_i == byte_addr(EXTENDED_ENABLE_ONE_IDX)
    || paddr_i == byte_addr(EXTENDED_PRIORITY_TWO_IDX))
    |=> !pslverr_o)
    else $error("mapped register access answered with an error");

  a_error_data_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    pready_o && pslverr_o |-> prdata_o == WORD_ZERO)
    else $error("refused access returned non-zero data");

  a_write_reads_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    psel_i && penable_i && pready_o && pwrite_i |-> prdata_o == WORD_ZERO)
    else $error("write answer carried non-zero data");
endmodule

// *** core_irq_partner.sv ***
// source side model: a bus controller that raises a level request on command.
// assumes one core clock shared with the register set.
module core_irq_partner (
  // clock
  input wire logic core_clk_i,
  // bench command and request to the register set
  input wire logic raise_i,
  output logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // request launched off the clock like a real same-domain source
  initial irq_o = 1'b0;
  always @(posedge core_clk_i) begin
    irq_o <= raise_i;
  end
endmodule

// *** interrupt_enable_priority_regs_bench.sv ***
// self-checking bench: apb register accesses and the request gate.
// assumes the apb slave answers with pready after a setup cycle.
module interrupt_enable_priority_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, raise = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq_raw, gated, px, en, pv, err;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  interrupt_enable_priority_regs dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .bus_function_controller_irq_i(irq_raw), .bus_function_controller_irq_o(gated),
    .ext_irq_zero_priority_o(px), .bus_controller_irq_enable_o(en),
    .supply_level_irq_priority_o(pv));
  core_irq_partner src (.core_clk_i(clk), .raise_i(raise), .irq_o(irq_raw));
  initial forever #12.5 clk = ~clk;
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr_rd(input logic [31:0] a, input logic [7:0] d, input logic [31:0] exp);
    apb(1'b1, a, {24'h000000, d});
    apb(1'b0, a, 32'h0);
    check({err, rd[30:0]}, exp);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({px, en, pv, gated}, 4'h0);
    apb(1'b0, 32'h00000398, 32'h0);
    check(rd, 32'h00000000);
    apb(1'b0, 32'h000003DC, 32'h0);
    check(rd, 32'h00000000);
    wr_rd(32'h00000080, 8'hFF, 32'h000000FF);
    check(px, 1'b1);
    wr_rd(32'h00000080, 8'hFE, 32'h000000FE);
    check(px, 1'b0);
    wr_rd(32'h00000398, 8'hFD, 32'h00000000);
    wr_rd(32'h00000398, 8'h01, 32'h00000000);
    check(en, 1'b0);
    wr_rd(32'h000003DC, 8'hFF, 32'h00000001);
    check(pv, 1'b1);
    wr_rd(32'h000003DC, 8'hFE, 32'h00000000);
    check(pv, 1'b0);
    // request while masked must stay blocked
    raise <= 1'b1;
    repeat (3) @(posedge clk);
    check(gated, 1'b0);
    wr_rd(32'h00000398, 8'hFF, 32'h00000002);
    check(en, 1'b1);
    check(gated, 1'b1);
    raise <= 1'b0;
    repeat (3) @(posedge clk);
    check(gated, 1'b0);
    raise <= 1'b1;
    wr_rd(32'h00000398, 8'h00, 32'h00000000);
    check(gated, 1'b0);
    // unmapped and misaligned places answer with an error
    apb(1'b0, 32'h00000004, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 32'h00000081, 32'h00000001);
    check(err, 1'b1);
    check(px, 1'b0);
    // a mapped index outside page zero is refused as well
    apb(1'b0, 32'h00000480, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    // reset in mid-run returns every setting to its low level
    wr_rd(32'h00000080, 8'h01, 32'h00000001);
    wr_rd(32'h00000398, 8'h02, 32'h00000002);
    wr_rd(32'h000003DC, 8'h01, 32'h00000001);
    check(gated, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({px, en, pv, gated}, 4'h0);
    apb(1'b0, 32'h00000080, 32'h0);
    check(rd, 32'h00000000);
    report_and_stop();
  end
endmodule
